// ==== nvac_params.svh ====
// Constants of the autosave and recall control block.
`ifndef NVAC_PARAMS_SVH
`define NVAC_PARAMS_SVH
// Command codes on the serial link.
`define NVAC_OP_SET_WRITE_LATCH 8'h06
`define NVAC_OP_READ_STATUS     8'h05
`define NVAC_OP_WRITE           8'h02
`define NVAC_OP_SECURE_WRITE    8'h12
`define NVAC_OP_WRITE_SERIAL    8'hC2
`define NVAC_OP_READ_SERIAL     8'hC3
`define NVAC_OP_STORE           8'h08
`define NVAC_OP_RECALL          8'h09
`define NVAC_OP_SLEEP           8'hB9
`define NVAC_OP_NONE            8'h00
// Frame layout counted in bytes, opcode byte included.
`define NVAC_SN_FRAME_BYTES     5'h11
`define NVAC_ADDR_HI_BYTE       5'h01
`define NVAC_ADDR_LO_BYTE       5'h02
`define NVAC_FIRST_DATA_BYTE    5'h03
// Status byte field positions.
`define NVAC_STAT_BUSY_BIT      0
`define NVAC_STAT_WLATCH_BIT    1
`define NVAC_STAT_AUTOSAVE_DIS  7
// Timing: durations in ns and the derived counts of 10 ns cycles.
`define NVAC_CLK_PERIOD_NS      10
`define NVAC_STORE_TIME_NS      8000000
`define NVAC_RECALL_TIME_NS     200000
`define NVAC_STORE_CYCLES       (`NVAC_STORE_TIME_NS / `NVAC_CLK_PERIOD_NS)
`define NVAC_RECALL_CYCLES      (`NVAC_RECALL_TIME_NS / `NVAC_CLK_PERIOD_NS)
`endif

// ==== nvac_pkg.sv ====
// Types shared by the autosave and recall control block.
package nvac_pkg;
  typedef enum logic [2:0] {
    NVAC_IDLE      = 3'b000,
    NVAC_RECALL    = 3'b001,
    NVAC_STORE     = 3'b010,
    NVAC_AUTOSTORE = 3'b011,
    NVAC_SLEEP     = 3'b100,
    NVAC_POWERDOWN = 3'b101
  } nvac_seq_type;
  typedef struct packed {
    logic        strobe;
    logic        secure;
    logic [15:0] addr;
    logic [7:0]  data;
  } nvac_wr_type;
  typedef struct packed {
    logic commit;
    logic discard;
  } nvac_sec_type;
endpackage

// ==== nvac_sync.sv ====
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
module nvac_sync #(
  parameter int             WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= INIT;
      q        <= INIT;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ==== nvac_ctrl.sv ====
// Serial command front end with store, recall, sleep and autosave sequencing.
`timescale 1ns/10ps
`include "nvac_params.svh"
module nvac_ctrl #(
  parameter int STORE_CYCLES  = `NVAC_STORE_CYCLES,
  parameter int RECALL_CYCLES = `NVAC_RECALL_CYCLES,
  parameter int CNT_W         = 20
) (
  // Clock and reset.
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // Serial link pins.
  input  wire logic                  CS_N,
  input  wire logic                  SCK,
  input  wire logic                  SI,
  output logic                       SO,
  output logic                       SO_OE_N,
  // Supply monitor and configuration.
  input  wire logic                  PWR_FAIL,
  input  wire logic                  AUTOSAVE_DISABLE,
  output logic                       HOLDUP_ISOLATE,
  // Array write port and secure write outcome.
  output nvac_pkg::nvac_wr_type      WR,
  output nvac_pkg::nvac_sec_type     SEC,
  // Sequencer state.
  output nvac_pkg::nvac_seq_type     STATE,
  output logic                       BUSY,
  output logic                       DIRTY
);
  import nvac_pkg::*;

  logic             cs_n_s, sck_s, si_s, pf_s, dis_s;
  logic             sck_d_reg, cs_d_reg, pf_d_reg;
  logic [2:0]       bit_cnt_reg;
  logic [4:0]       byte_cnt_reg;
  logic [7:0]       rx_reg, op_reg;
  logic [15:0]      addr_reg;
  logic             wlatch_reg, tx_en_reg;
  logic [127:0]     tx_reg, sn_stage_reg, sn_vol_reg, sn_nv_reg;
  logic [CNT_W-1:0] cnt_reg, cnt_next, cnt_limit;
  logic             recall_req_reg, dirty_reg;
  nvac_seq_type     seq_reg, seq_next;
  logic [7:0]       status_w;

  // Pins and the supply monitor pass two flip-flops first.
  nvac_sync #(.WIDTH(5), .INIT(5'h10)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({CS_N, SCK, SI, PWR_FAIL, AUTOSAVE_DISABLE}),
    .q   ({cs_n_s, sck_s, si_s, pf_s, dis_s})
  );

  // Edge detection on the synchronised link signals.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
      pf_d_reg  <= 1'b0;
    end
    else
    begin
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_n_s;
      pf_d_reg  <= pf_s;
    end
  end

  // Link is dead while asleep, powered down or storing on power loss.
  wire link_off  = pf_s || seq_reg == NVAC_SLEEP || seq_reg == NVAC_AUTOSTORE
                   || seq_reg == NVAC_POWERDOWN;
  wire sck_rise  = sck_s && !sck_d_reg && !cs_n_s && !link_off;
  wire sck_fall  = !sck_s && sck_d_reg && !cs_n_s && !link_off;
  wire cs_rise   = cs_n_s && !cs_d_reg && !link_off;
  wire cs_fall   = !cs_n_s && cs_d_reg;
  wire pf_rise   = pf_s && !pf_d_reg;
  wire [7:0] rx_byte  = {rx_reg[6:0], si_s};
  wire byte_done = sck_rise && bit_cnt_reg == 3'h7;
  wire op_load   = byte_done && byte_cnt_reg == 5'h00;

  // Opcode admission: status read only while busy, latch for writes.
  wire busy_seq  = seq_reg == NVAC_RECALL || seq_reg == NVAC_STORE;
  wire op_ok     = seq_reg == NVAC_IDLE
                   || (busy_seq && rx_byte == `NVAC_OP_READ_STATUS);
  wire rx_needs_latch = rx_byte == `NVAC_OP_WRITE || rx_byte == `NVAC_OP_SECURE_WRITE
                        || rx_byte == `NVAC_OP_WRITE_SERIAL;
  wire op_needs_latch = op_reg == `NVAC_OP_WRITE || op_reg == `NVAC_OP_SECURE_WRITE
                        || op_reg == `NVAC_OP_WRITE_SERIAL;
  wire op_accept = op_ok && !(rx_needs_latch && !wlatch_reg);
  wire is_arr_wr = op_reg == `NVAC_OP_WRITE || op_reg == `NVAC_OP_SECURE_WRITE;
  wire is_secure = op_reg == `NVAC_OP_SECURE_WRITE;
  wire data_byte = byte_done && is_arr_wr && byte_cnt_reg >= `NVAC_FIRST_DATA_BYTE;
  wire frame_one = cs_rise && byte_cnt_reg == 5'h01 && bit_cnt_reg == 3'h0;
  wire sn_commit = cs_rise && op_reg == `NVAC_OP_WRITE_SERIAL
                   && byte_cnt_reg == `NVAC_SN_FRAME_BYTES && bit_cnt_reg == 3'h0;
  wire sec_done  = cs_rise && is_secure && bit_cnt_reg == 3'h0
                   && byte_cnt_reg >= `NVAC_FIRST_DATA_BYTE;
  wire save_ok   = dirty_reg && !dis_s;
  wire [4:0] byte_cnt_inc = (byte_cnt_reg == 5'h1F) ? 5'h1F : 5'(byte_cnt_reg + 5'h01);

  // Status byte as shifted out on a status read.
  always_comb
  begin
    status_w = 8'h00;
    status_w[`NVAC_STAT_BUSY_BIT]     = busy_seq;
    status_w[`NVAC_STAT_WLATCH_BIT]   = wlatch_reg;
    status_w[`NVAC_STAT_AUTOSAVE_DIS] = dis_s;
  end

  // Bit and byte framing; deselect or power fail drops a partial byte.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 5'h00;
      rx_reg       <= 8'h00;
      op_reg       <= `NVAC_OP_NONE;
    end
    else if (cs_n_s || link_off)
    begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 5'h00;
      op_reg       <= `NVAC_OP_NONE;
    end
    else if (sck_rise)
    begin
      rx_reg      <= rx_byte;
      bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
      if (bit_cnt_reg == 3'h7)
        byte_cnt_reg <= byte_cnt_inc;
      if (op_load)
        op_reg <= op_accept ? rx_byte : `NVAC_OP_NONE;
    end
  end

  // Address capture and array write strobes, one per whole byte.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      addr_reg <= 16'h0000;
      WR       <= '0;
    end
    else
    begin
      WR.strobe <= data_byte;
      if (byte_done && is_arr_wr && byte_cnt_reg == `NVAC_ADDR_HI_BYTE)
        addr_reg[15:8] <= rx_byte;
      else if (byte_done && is_arr_wr && byte_cnt_reg == `NVAC_ADDR_LO_BYTE)
        addr_reg[7:0] <= rx_byte;
      else if (data_byte)
      begin
        WR.secure <= is_secure;
        WR.addr   <= addr_reg;
        WR.data   <= rx_byte;
        addr_reg  <= 16'(addr_reg + 16'h0001);
      end
    end
  end

  // Secure write outcome: commit on clean deselect, discard on power fail.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      SEC <= '0;
    else
    begin
      SEC.commit  <= sec_done;
      SEC.discard <= pf_rise && is_secure;
    end
  end

  // Write latch: set by its command, cleared after a write frame or power fail.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      wlatch_reg <= 1'b0;
    else if (op_load && op_ok && rx_byte == `NVAC_OP_SET_WRITE_LATCH)
      wlatch_reg <= 1'b1;
    else if (pf_s || (cs_rise && op_needs_latch))
      wlatch_reg <= 1'b0;
  end

  // Serial number staging, volatile copy and non-volatile copy.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sn_stage_reg <= '0;
      sn_vol_reg   <= '0;
      sn_nv_reg    <= '0;
    end
    else
    begin
      if (byte_done && op_reg == `NVAC_OP_WRITE_SERIAL && byte_cnt_reg != 5'h00
          && byte_cnt_reg < `NVAC_SN_FRAME_BYTES)
        sn_stage_reg <= {sn_stage_reg[119:0], rx_byte};
      if (sn_commit)
        sn_vol_reg <= sn_stage_reg;
      else if (seq_next == NVAC_RECALL && seq_reg != NVAC_RECALL)
        sn_vol_reg <= sn_nv_reg;
      if ((seq_next == NVAC_STORE && seq_reg != NVAC_STORE)
          || (seq_next == NVAC_AUTOSTORE && seq_reg != NVAC_AUTOSTORE))
        sn_nv_reg <= sn_vol_reg;
    end
  end

  // Read data: loaded after the opcode, shifted out on falling clock edges.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_reg    <= '0;
      tx_en_reg <= 1'b0;
      SO        <= 1'b0;
      SO_OE_N   <= 1'b1;
    end
    else
    begin
      SO_OE_N <= !(tx_en_reg && !cs_n_s && !link_off);
      if (cs_n_s || link_off)
        tx_en_reg <= 1'b0;
      else if (op_load && op_accept && rx_byte == `NVAC_OP_READ_STATUS)
      begin
        tx_reg    <= {16{status_w}};
        tx_en_reg <= 1'b1;
      end
      else if (op_load && op_accept && rx_byte == `NVAC_OP_READ_SERIAL)
      begin
        tx_reg    <= sn_vol_reg;
        tx_en_reg <= 1'b1;
      end
      else if (sck_fall && tx_en_reg)
      begin
        SO     <= tx_reg[127];
        tx_reg <= {tx_reg[126:0], 1'b0};
      end
    end
  end

  // Sequencer next state; power fail overrides every transition from idle, recall, store and sleep.
  assign cnt_limit = (seq_reg == NVAC_RECALL) ? CNT_W'(RECALL_CYCLES - 1)
                                              : CNT_W'(STORE_CYCLES - 1);
  wire cnt_done = cnt_reg == cnt_limit;
  always_comb
  begin
    seq_next = seq_reg;
    case (seq_reg)
      NVAC_IDLE:
        if (recall_req_reg && !pf_s)
          seq_next = NVAC_RECALL;
        else if (frame_one && op_reg == `NVAC_OP_STORE)
          seq_next = NVAC_STORE;
        else if (frame_one && op_reg == `NVAC_OP_RECALL)
          seq_next = NVAC_RECALL;
        else if (frame_one && op_reg == `NVAC_OP_SLEEP)
          seq_next = NVAC_SLEEP;
      NVAC_RECALL, NVAC_STORE:
        if (cnt_done)
          seq_next = NVAC_IDLE;
      NVAC_AUTOSTORE:
        if (cnt_done)
          seq_next = NVAC_POWERDOWN;
      NVAC_SLEEP:
        if (cs_fall)
          seq_next = NVAC_RECALL;
      NVAC_POWERDOWN:
        if (!pf_s)
          seq_next = NVAC_IDLE;
      default:
        seq_next = NVAC_IDLE;
    endcase
    if (pf_s && seq_reg != NVAC_AUTOSTORE && seq_reg != NVAC_POWERDOWN)
      seq_next = save_ok ? NVAC_AUTOSTORE : NVAC_POWERDOWN;
    cnt_next = (seq_next != seq_reg) ? '0 : CNT_W'(cnt_reg + 1'b1);
  end

  // Sequencer state, cycle counter and registered status outputs.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      seq_reg        <= NVAC_IDLE;
      cnt_reg        <= '0;
      STATE          <= NVAC_IDLE;
      BUSY           <= 1'b0;
      HOLDUP_ISOLATE <= 1'b0;
    end
    else
    begin
      seq_reg        <= seq_next;
      cnt_reg        <= cnt_next;
      STATE          <= seq_next;
      BUSY           <= seq_next == NVAC_RECALL || seq_next == NVAC_STORE
                        || seq_next == NVAC_AUTOSTORE;
      HOLDUP_ISOLATE <= pf_s;
    end
  end

  // Recall request and dirty flag; a set wins over a clear.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      recall_req_reg <= 1'b1;
      dirty_reg      <= 1'b0;
      DIRTY          <= 1'b0;
    end
    else
    begin
      if (pf_s)
        recall_req_reg <= 1'b1;
      else if (seq_next == NVAC_RECALL)
        recall_req_reg <= 1'b0;
      if (data_byte || sn_commit)
        dirty_reg <= 1'b1;
      else if (seq_next != seq_reg && (seq_next == NVAC_RECALL
               || seq_next == NVAC_STORE || seq_next == NVAC_AUTOSTORE))
        dirty_reg <= 1'b0;
      DIRTY <= dirty_reg;
    end
  end

  // Checks of the behaviour above.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_latch_before_write;
    WR.strobe |-> $past(wlatch_reg);
  endproperty
  a_latch_before_write: assert property (p_latch_before_write)
    else $error("Array write issued without the write latch.");

  property p_sn_whole;
    sn_commit |=> sn_vol_reg == $past(sn_stage_reg) && $past(byte_cnt_reg) == 5'h11;
  endproperty
  a_sn_whole: assert property (p_sn_whole)
    else $error("Serial number committed from a short frame.");

  property p_store_copies_sn;
    seq_reg == NVAC_IDLE ##1 seq_reg == NVAC_STORE |-> sn_nv_reg == $past(sn_vol_reg);
  endproperty
  a_store_copies_sn: assert property (p_store_copies_sn)
    else $error("Store did not copy the serial number.");

  property p_sleep_holds;
    seq_reg == NVAC_SLEEP && !cs_fall && !pf_s |=> seq_reg == NVAC_SLEEP && SO_OE_N;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("Sleep left without a select edge.");

  property p_wake_recall;
    seq_reg == NVAC_SLEEP && cs_fall && !pf_s |=> seq_reg == NVAC_RECALL ##0 BUSY;
  endproperty
  a_wake_recall: assert property (p_wake_recall)
    else $error("Select in sleep did not start a recall.");

  property p_autosave;
    pf_rise && save_ok && seq_reg == NVAC_IDLE |=> seq_reg == NVAC_AUTOSTORE && HOLDUP_ISOLATE;
  endproperty
  a_autosave: assert property (p_autosave)
    else $error("Power fail did not start the autosave.");

  property p_pf_no_write;
    pf_s ##1 pf_s |-> !WR.strobe;
  endproperty
  a_pf_no_write: assert property (p_pf_no_write)
    else $error("Array write issued during power fail.");

  property p_skip_store;
    pf_rise && !save_ok && seq_reg == NVAC_IDLE |=> seq_reg == NVAC_POWERDOWN;
  endproperty
  a_skip_store: assert property (p_skip_store)
    else $error("Autosave ran although clean or disabled.");

  property p_return_recall;
    seq_reg == NVAC_POWERDOWN && !pf_s |=> seq_reg == NVAC_IDLE ##1 seq_reg == NVAC_RECALL;
  endproperty
  a_return_recall: assert property (p_return_recall)
    else $error("Supply return did not start a recall.");

  property p_status_busy;
    seq_reg == NVAC_RECALL |-> status_w[0] && BUSY;
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("Status bit 0 clear during recall.");

  property p_autosave_silent;
    seq_reg == NVAC_AUTOSTORE && $past(seq_reg) == NVAC_AUTOSTORE |-> SO_OE_N;
  endproperty
  a_autosave_silent: assert property (p_autosave_silent)
    else $error("Output driven during autosave.");

  c_autosave: cover property (seq_reg == NVAC_IDLE ##1 seq_reg == NVAC_AUTOSTORE);
  c_wake: cover property (seq_reg == NVAC_SLEEP ##1 seq_reg == NVAC_RECALL);
  c_sn_commit: cover property (sn_commit);
  c_sec_discard: cover property (SEC.discard);
endmodule

// ==== nvac_host.sv ====
// Serial link host model that frames commands toward the control block.
`timescale 1ns/10ps
module nvac_host (
  // Bench clock.
  input  wire logic clk,
  // Link pins toward the block.
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic [7:0] rx [0:16];
  logic       oe_seen;

  // The link clock idles low and select idles high outside frames.
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    oe_seen = 1'b0;
  end

  // Half a link clock period is four bench cycles, so the period is 80 ns.
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Sends the opcode, then bytes of seed plus index, then a partial byte of extra bits.
  task automatic frame(input logic [7:0] op, input logic [7:0] seed,
                       input int nbytes, input int extra);
    logic [7:0] tx;
    int         nbits;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    half();
    for (int k = 0; k < nbytes + ((extra > 0) ? 1 : 0); k++)
    begin
      tx = (k == 0) ? op : seed + 8'(k);
      nbits = (k < nbytes) ? 8 : extra;
      for (int b = 0; b < nbits; b++)
      begin
        si = tx[7 - b];
        half();
        sck = 1'b1;
        half();
        if (k < 17) rx[k][7 - b] = so;
        if (so_oe_n === 1'b0) oe_seen = 1'b1;
        sck = 1'b0;
      end
    end
    half();
    cs_n = 1'b1;
    si = ~si; // A released data line shows no stale bit.
    repeat (6) @(posedge clk);
    #1;
  endtask
endmodule

// ==== nvac_ctrl_tb.sv ====
// Self-checking bench of the autosave and recall control block.
`timescale 1ns/10ps
`include "nvac_params.svh"
`define NVTB_CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module nvac_ctrl_tb;
  import nvac_pkg::*;
  localparam int SC = 600;
  localparam int RC = 400;
  logic         clk, rst, cs_n, sck, si, so, so_oe_n;
  logic         pwr, dis, holdup, busy, dirty;
  nvac_wr_type  wr, wr_last;
  nvac_sec_type sec;
  nvac_seq_type state;
  int           fail_count, checks_done, cycles, wr_count, disc_count, commit_count;
  int           base, busy_run, last_run;

  nvac_ctrl #(.STORE_CYCLES(SC), .RECALL_CYCLES(RC)) u_dut (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE_N(so_oe_n),
    .PWR_FAIL(pwr), .AUTOSAVE_DISABLE(dis), .HOLDUP_ISOLATE(holdup), .WR(wr),
    .SEC(sec), .STATE(state), .BUSY(busy), .DIRTY(dirty));
  nvac_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));

  // Bench clock of 10 ns.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Counts write strobes, secure outcomes and busy run lengths; cuts a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (wr.strobe === 1'b1) wr_last = wr;
    if (wr.strobe === 1'b1) wr_count++;
    if (sec.discard === 1'b1) disc_count++;
    if (sec.commit === 1'b1) commit_count++;
    if (busy === 1'b1) busy_run++;
    else if (busy_run != 0)
    begin
      last_run = busy_run;
      busy_run = 0;
    end
    if (cycles == 40000)
    begin
      fail_count++;
      test_done();
    end
  end

  // Waits n edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Reads the status byte and compares it.
  task automatic status_is(input logic [7:0] exp);
    u_host.frame(`NVAC_OP_READ_STATUS, 8'h00, 2, 0);
    `NVTB_CHK("status", exp, u_host.rx[1])
    `NVTB_CHK("enable", 1'b1, u_host.oe_seen)
  endtask

  // Reads all sixteen serial bytes and compares them with seed plus index.
  task automatic sn_is(input logic [7:0] seed);
    u_host.frame(`NVAC_OP_READ_SERIAL, 8'h00, 17, 0);
    for (int k = 1; k < 17; k++) `NVTB_CHK("serial", seed + 8'(k), u_host.rx[k])
  endtask

  // Waits a bounded time for a sequencer state.
  task automatic wait_state(input nvac_seq_type s, input int lim);
    for (int n = 0; n < lim && state !== s; n++) tick(1);
    `NVTB_CHK("state", s, state)
  endtask

  // Sets the write latch.
  task automatic latch();
    u_host.frame(`NVAC_OP_SET_WRITE_LATCH, 8'h00, 1, 0);
  endtask

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    pwr = 1'b0;
    dis = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);
    `NVTB_CHK("state", NVAC_RECALL, state)
    `NVTB_CHK("busy", 1'b1, busy)
    status_is(8'h01);
    latch();
    status_is(8'h01);
    wait_state(NVAC_IDLE, 1000);
    status_is(8'h00);
    u_host.frame(`NVAC_OP_WRITE, 8'h10, 5, 0);
    tick(4);
    `NVTB_CHK("strobes", 0, wr_count)
    `NVTB_CHK("dirty", 1'b0, dirty)
    latch();
    u_host.frame(`NVAC_OP_WRITE, 8'h10, 5, 3);
    tick(4);
    `NVTB_CHK("strobes", 2, wr_count)
    `NVTB_CHK("addr", 16'h1113, wr_last.addr)
    `NVTB_CHK("data", 8'h14, wr_last.data)
    `NVTB_CHK("dirty", 1'b1, dirty)
    status_is(8'h00);
    latch();
    u_host.frame(`NVAC_OP_WRITE_SERIAL, 8'h40, 17, 0);
    sn_is(8'h40);
    u_host.frame(`NVAC_OP_STORE, 8'h00, 1, 0);
    tick(2);
    `NVTB_CHK("state", NVAC_STORE, state)
    latch();
    status_is(8'h01);
    wait_state(NVAC_IDLE, 1000);
    // The run length is only recorded at the edge after busy has fallen.
    tick(2);
    `NVTB_CHK("store length", 1'b1, last_run >= SC && last_run <= SC + 1)
    `NVTB_CHK("dirty", 1'b0, dirty)
    latch();
    u_host.frame(`NVAC_OP_WRITE_SERIAL, 8'h80, 16, 0);
    sn_is(8'h40);
    latch();
    u_host.frame(`NVAC_OP_WRITE_SERIAL, 8'h80, 17, 0);
    sn_is(8'h80);
    u_host.frame(`NVAC_OP_RECALL, 8'h00, 1, 0);
    tick(2);
    wait_state(NVAC_IDLE, 1000);
    sn_is(8'h40);
    `NVTB_CHK("dirty", 1'b0, dirty)
    pwr = 1'b1;
    tick(6);
    `NVTB_CHK("state", NVAC_POWERDOWN, state)
    `NVTB_CHK("isolate", 1'b1, holdup)
    pwr = 1'b0;
    tick(6);
    `NVTB_CHK("state", NVAC_RECALL, state)
    wait_state(NVAC_IDLE, 1000);
    latch();
    u_host.frame(`NVAC_OP_WRITE_SERIAL, 8'hA0, 17, 0);
    latch();
    base = wr_count;
    // Supply drops after two bits of the second data byte have been shifted.
    fork
      u_host.frame(`NVAC_OP_WRITE, 8'h20, 4, 5);
      begin
        tick(4 + 34 * 8);
        pwr = 1'b1;
      end
    join
    `NVTB_CHK("strobes", base + 1, wr_count)
    `NVTB_CHK("data", 8'h23, wr_last.data)
    `NVTB_CHK("state", NVAC_AUTOSTORE, state)
    `NVTB_CHK("busy", 1'b1, busy)
    `NVTB_CHK("isolate", 1'b1, holdup)
    u_host.frame(`NVAC_OP_READ_STATUS, 8'h00, 2, 0);
    `NVTB_CHK("answer", 1'b0, u_host.oe_seen)
    wait_state(NVAC_POWERDOWN, 1000);
    pwr = 1'b0;
    tick(6);
    wait_state(NVAC_IDLE, 1000);
    sn_is(8'hA0);
    latch();
    // Supply drops in the partial byte after two secure data bytes.
    fork
      u_host.frame(`NVAC_OP_SECURE_WRITE, 8'h30, 5, 4);
      begin
        tick(4 + 41 * 8);
        pwr = 1'b1;
      end
    join
    `NVTB_CHK("discard", 1, disc_count)
    `NVTB_CHK("commit", 0, commit_count)
    wait_state(NVAC_POWERDOWN, 1000);
    pwr = 1'b0;
    tick(6);
    wait_state(NVAC_IDLE, 1000);
    dis = 1'b1;
    latch();
    u_host.frame(`NVAC_OP_WRITE, 8'h50, 4, 0);
    status_is(8'h80);
    pwr = 1'b1;
    tick(6);
    `NVTB_CHK("state", NVAC_POWERDOWN, state)
    dis = 1'b0;
    pwr = 1'b0;
    tick(6);
    wait_state(NVAC_IDLE, 1000);
    latch();
    status_is(8'h02);
    u_host.frame(`NVAC_OP_SECURE_WRITE, 8'h60, 4, 0);
    tick(2);
    `NVTB_CHK("commit", 1, commit_count)
    `NVTB_CHK("secure", 1'b1, wr_last.secure)
    `NVTB_CHK("data", 8'h63, wr_last.data)
    u_host.frame(`NVAC_OP_SLEEP, 8'h00, 1, 0);
    tick(2);
    `NVTB_CHK("state", NVAC_SLEEP, state)
    latch();
    `NVTB_CHK("state", NVAC_RECALL, state)
    status_is(8'h01);
    wait_state(NVAC_IDLE, 1000);
    test_done();
  end
endmodule
